// >>> clock_selector_defs.svh
`ifndef CLOCK_SELECTOR_DEFS_SVH
`define CLOCK_SELECTOR_DEFS_SVH

// Selection mode codes
`define MODE_MANUAL 2'h0
`define MODE_AUTO_NONREV 2'h1
`define MODE_AUTO_REV 2'h2
`define MODE_RESERVED 2'h3

// Input pairing codes
`define PAIRING_INDEPENDENT 1'h0
`define PAIRING_PAIRED 1'h1

// Reset values of the outputs and of the held choice
`define ACTIVE_CHOICE_RESET 2'h0
`define ACTIVE_ONEHOT_RESET 4'h1

// Validation code at or above which a switch is hitless
`define VALIDATION_HITLESS_MIN 2'h1

// Lock lost indication length around a switch, in ns, and its cycle count
`define LOCK_LOST_TIME_NS 100
`define CLOCK_PERIOD_NS 10
`define LOCK_LOST_CYCLES ((`LOCK_LOST_TIME_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)

`endif

// >>> clock_selector_pkg.sv
package clock_selector_pkg;

	// Selector decision states, one-hot
	typedef enum logic [2:0] {
		state_reset_type = 3'h1,
		state_locked_type = 3'h2,
		state_hold_type = 3'h4
	} select_state_type;

endpackage : clock_selector_pkg

// >>> alarm_qualifier.sv
`timescale 1ns/10ps
`include "clock_selector_defs.svh"

module alarm_qualifier #(
	parameter int INPUTS = 4
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [INPUTS-1:0] loss_alarm_i,
	input wire logic [INPUTS-1:0] offset_alarm_i,
	input wire logic offset_alarm_enable_i,
	input wire logic input_pairing_config_i,
	output logic [INPUTS-1:0] candidate_bad_o
);

	////////////////////////////////////////////////////////////////////////
	// Per-input qualified alarm
	logic [INPUTS-1:0] qualified; // Loss plus enabled offset alarm

	genvar g;
	generate
		for (g = 0; g < INPUTS; g++) begin : gen_qual
			// Loss always counts, offset only when enabled
			assign qualified[g] = loss_alarm_i[g] | (offset_alarm_i[g] & offset_alarm_enable_i); // R19 R12 R13
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Candidate badness, registered so the selector sees a clean level
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			candidate_bad_o <= '1;
		end else if (input_pairing_config_i == `PAIRING_PAIRED && INPUTS == 4) begin
			// A pair is bad when either its clock or its frame sync is bad
			candidate_bad_o <= INPUTS'({2'h3, qualified[3] | qualified[1],
				qualified[2] | qualified[0]}); // R1
		end else begin
			candidate_bad_o <= qualified;
		end
	end

endmodule : alarm_qualifier

// >>> input_clock_selector.sv
`timescale 1ns/10ps
`include "clock_selector_defs.svh"
// Behaviour
// R1: Pairing config: independent inputs or clock/sync pairs
// R2: Mode 00 selects manually
// R3: Manual code maps to input or pair
// R4: Pin enable picks pins over register
// R5: Manual alarmed input means digital hold
// R6: Automatic modes ignore manual register choice
// R7: 01 non-revertive, 10 revertive, 11 reserved
// R8: Pin enable matters only in manual
// R9: Two-input priority default or inverted
// R10: Highest priority at reset; revertive returns
// R11: Alarm steps down priority, else hold
// R12: Disabled offset alarms cause no switch
// R13: Loss alarms always count
// R14: Non-revertive keeps valid lower input
// R15: Rank fields name input per rank
// R16: Paired uses only first two ranks
// R17: Lock lost may pulse on switching
// R18: Hitless only when validation at least 01
// R19: Qualified alarm is loss or enabled offset
// R20: Reevaluate each cycle, drive choice and hold

module input_clock_selector
	import clock_selector_pkg::*;
#(
	parameter int INPUTS = 4, // 4 or 2
	parameter int LOCK_LOST_LEN = `LOCK_LOST_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic input_pairing_config_i, // 0 independent, 1 paired
	input wire logic [1:0] selection_mode_i,
	input wire logic [1:0] manual_input_choice_i,
	input wire logic pin_choice_enable_i,
	input wire logic [1:0] clock_choice_pins_i,
	input wire logic priority_order_i, // Two-input: 1 ranks input2 first
	input wire logic [1:0] rank_1_source_i,
	input wire logic [1:0] rank_2_source_i,
	input wire logic [1:0] rank_3_source_i,
	input wire logic [1:0] rank_4_source_i,
	input wire logic [1:0] validation_period_i,
	input wire logic offset_alarm_enable_i,
	input wire logic [INPUTS-1:0] loss_alarm_i,
	input wire logic [INPUTS-1:0] offset_alarm_i,
	output logic [1:0] active_choice_o,
	output logic [INPUTS-1:0] active_onehot_o,
	output logic digital_hold_o,
	output logic switch_pulse_o,
	output logic hitless_o,
	output logic lock_lost_o
);

	////////////////////////////////////////////////////////////////////////
	// Decoding helpers

	// Code to one-hot, used for the one-hot active output
	function automatic logic [3:0] decode_choice(input logic [1:0] code);
		logic [3:0] r;
		r = 4'h0;
		r[code] = 1'b1;
		return r;
	endfunction : decode_choice

	// Whether a code names a usable candidate in the current arrangement
	function automatic logic code_usable(input logic [1:0] code, input logic paired);
		logic ok;
		ok = 1'b1;
		if (paired && code[1]) begin
			ok = 1'b0; // R3 R15
		end
		if (INPUTS == 2 && code[1]) begin
			ok = 1'b0;
		end
		return ok;
	endfunction : code_usable

	////////////////////////////////////////////////////////////////////////
	// Alarm qualification
	logic [INPUTS-1:0] candidate_bad; // Registered per-candidate alarm

	alarm_qualifier #(
		.INPUTS(INPUTS)
	) u_alarm_qualifier (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.loss_alarm_i(loss_alarm_i),
		.offset_alarm_i(offset_alarm_i),
		.offset_alarm_enable_i(offset_alarm_enable_i),
		.input_pairing_config_i(input_pairing_config_i),
		.candidate_bad_o(candidate_bad)
	);

	// Pad to four so all indexing below is uniform
	logic [3:0] bad4;
	assign bad4 = 4'(candidate_bad) | ~4'((1 << INPUTS) - 1);

	logic paired; // Pairing only exists on the four-input variant
	assign paired = (INPUTS == 4) && (input_pairing_config_i == `PAIRING_PAIRED); // R1

	////////////////////////////////////////////////////////////////////////
	// Priority list
	logic [1:0] rank [4]; // Candidate code at each rank
	logic [3:0] rank_used; // Rank takes part in the search

	always_comb begin
		rank[0] = rank_1_source_i;
		rank[1] = rank_2_source_i;
		rank[2] = rank_3_source_i;
		rank[3] = rank_4_source_i;
		rank_used = 4'hf;
		if (INPUTS == 2) begin
			// Two-input variants: a single priority order bit
			rank[0] = priority_order_i ? 2'h1 : 2'h0; // R9
			rank[1] = priority_order_i ? 2'h0 : 2'h1; // R9
			rank_used = 4'h3;
		end else if (paired) begin
			rank_used = 4'h3; // R16
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Manual choice source
	logic [1:0] manual_code; // Pins or register, manual only

	always_comb begin
		// Pin enable consulted here only, so automatic never sees it
		manual_code = pin_choice_enable_i ? clock_choice_pins_i : manual_input_choice_i; // R4 R8
		if (INPUTS == 2) begin
			manual_code = {1'b0, manual_code[0]}; // R3
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Automatic search: best valid rank and position of current choice
	logic best_found; // Some ranked candidate is alarm free
	logic [1:0] best_code; // Highest ranked alarm free candidate
	logic [1:0] best_rank;
	logic cur_found; // Current choice appears in the used ranks
	logic [1:0] cur_rank;
	logic lower_found; // Some alarm free candidate ranks below the current one
	logic [1:0] lower_code; // First alarm free candidate below the current rank

	always_comb begin
		best_found = 1'b0;
		best_code = 2'h0;
		best_rank = 2'h0;
		cur_found = 1'b0;
		cur_rank = 2'h3;
		// Walk from lowest to highest so the highest rank wins last
		for (int i = 3; i >= 0; i--) begin
			if (rank_used[i] && code_usable(rank[i], paired)) begin
				if (!bad4[rank[i]]) begin
					best_found = 1'b1; // R11
					best_code = rank[i];
					best_rank = 2'(i);
				end
				if (rank[i] == active_choice_o) begin
					cur_found = 1'b1;
					cur_rank = 2'(i);
				end
			end
		end
		// Second walk: nearest valid rank below the current one
		lower_found = 1'b0;
		lower_code = 2'h0;
		for (int i = 3; i >= 0; i--) begin
			if (rank_used[i] && code_usable(rank[i], paired) && (2'(i) > cur_rank)) begin
				if (!bad4[rank[i]]) begin
					lower_found = 1'b1; // R11
					lower_code = rank[i];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Next decision
	logic [1:0] next_choice;
	logic next_hold;
	logic auto_mode;
	select_state_type state;

	assign auto_mode = (selection_mode_i == `MODE_AUTO_NONREV) ||
		(selection_mode_i == `MODE_AUTO_REV); // R7

	always_comb begin
		next_choice = active_choice_o;
		next_hold = digital_hold_o;
		if (state == state_reset_type) begin
			// In automatic modes the first decision after reset still sees every input alarmed, so it holds on the highest ranked input
			next_choice = best_found ? best_code : rank[0]; // R10
			next_hold = !best_found; // R10
			if (!auto_mode) begin
				next_choice = manual_code;
				next_hold = bad4[manual_code] || !code_usable(manual_code, paired);
			end
		end else if (selection_mode_i == `MODE_MANUAL) begin
			// Manual: never hunt for another input, hold instead
			next_choice = manual_code; // R2 R3
			next_hold = bad4[manual_code] || !code_usable(manual_code, paired); // R5
		end else if (auto_mode) begin
			// Manual register ignored in this branch entirely
			if (!best_found) begin
				next_hold = 1'b1; // R11 R6
			end else if (selection_mode_i == `MODE_AUTO_REV) begin
				next_choice = best_code; // R10
				next_hold = 1'b0;
			end else if (digital_hold_o || !cur_found) begin
				// Leaving hold or an unranked input: take the best valid one
				next_choice = best_code; // R11
				next_hold = 1'b0;
			end else if (bad4[active_choice_o]) begin
				// Current lost: step down to next valid rank, else best valid
				next_choice = lower_found ? lower_code : best_code; // R11
				next_hold = 1'b0;
			end else begin
				// Non-revertive: keep a still valid input
				next_choice = active_choice_o; // R14
				next_hold = 1'b0;
			end
		end
		// Reserved mode code keeps the present decision; only the first decision after reset follows the manual code (R7)
	end

	////////////////////////////////////////////////////////////////////////
	// State, evaluated every cycle
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= state_reset_type;
		end else begin
			unique case (state)
				state_reset_type: state <= next_hold ? state_hold_type : state_locked_type;
				state_locked_type: state <= next_hold ? state_hold_type : state_locked_type;
				state_hold_type: state <= next_hold ? state_hold_type : state_locked_type;
			endcase
		end
	end

	// Registered decision outputs
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			active_choice_o <= `ACTIVE_CHOICE_RESET;
			active_onehot_o <= INPUTS'(`ACTIVE_ONEHOT_RESET);
			digital_hold_o <= 1'b0;
		end else begin
			active_choice_o <= next_choice; // R20
			active_onehot_o <= next_hold ? '0 : INPUTS'(decode_choice(next_choice)); // R20
			digital_hold_o <= next_hold; // R20
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Switch event, hitless flag and lock lost window
	logic switching;
	logic [$clog2(LOCK_LOST_LEN+1)-1:0] lock_lost_count;

	// A switch is a change of active input, or a return from hold, while not holding
	assign switching = (state != state_reset_type) && !next_hold &&
		(digital_hold_o || next_choice != active_choice_o);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			switch_pulse_o <= 1'b0;
			hitless_o <= 1'b0;
		end else begin
			switch_pulse_o <= switching;
			if (switching) begin
				hitless_o <= validation_period_i >= `VALIDATION_HITLESS_MIN; // R18
			end
		end
	end

	// Lock lost is only a hint here; the loop detector owns the real status
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			lock_lost_count <= '0;
			lock_lost_o <= 1'b0;
		end else if (switching && validation_period_i < `VALIDATION_HITLESS_MIN) begin
			lock_lost_count <= ($clog2(LOCK_LOST_LEN+1))'(LOCK_LOST_LEN); // R17
			lock_lost_o <= 1'b1;
		end else if (lock_lost_count != '0) begin
			lock_lost_count <= lock_lost_count - 1'b1;
			lock_lost_o <= (lock_lost_count != 1);
		end else begin
			lock_lost_o <= 1'b0;
		end
	end

endmodule : input_clock_selector

// >>> input_clock_selector_checker.sv
`timescale 1ns/10ps
module selector_checker #(
	parameter int INPUTS = 4
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic input_pairing_config_i,
	input wire logic [1:0] selection_mode_i,
	input wire logic [1:0] manual_input_choice_i,
	input wire logic pin_choice_enable_i,
	input wire logic [1:0] clock_choice_pins_i,
	input wire logic [1:0] rank_1_source_i,
	input wire logic offset_alarm_enable_i,
	input wire logic [INPUTS-1:0] loss_alarm_i,
	input wire logic [INPUTS-1:0] offset_alarm_i,
	input wire logic [1:0] active_choice_o,
	input wire logic [INPUTS-1:0] active_onehot_o,
	input wire logic digital_hold_o,
	input wire logic switch_pulse_o,
	input wire logic lock_lost_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Three quiet edges cover the two-edge alarm latency
	wire quiet = !input_pairing_config_i && loss_alarm_i == '0 && offset_alarm_i == '0;
	wire man = !input_pairing_config_i && selection_mode_i == 2'h0;
	////////////////////////////////////////////////////////////////////////////////
	chk_manual_pick: assert property ((quiet && man && !pin_choice_enable_i)[*3]
		|=> active_choice_o == $past(manual_input_choice_i)) else $error("manual pick");
	chk_pin_pick: assert property ((quiet && man && pin_choice_enable_i)[*3]
		|=> active_choice_o == $past(clock_choice_pins_i)) else $error("pin pick");
	chk_manual_hold: assert property ((man && !pin_choice_enable_i && $stable(manual_input_choice_i)
		&& loss_alarm_i[manual_input_choice_i])[*3] |=> digital_hold_o) else $error("no hold");
	chk_auto_revert: assert property ((quiet && selection_mode_i == 2'h2)[*3]
		|=> !digital_hold_o && active_choice_o == $past(rank_1_source_i)) else $error("revert");
	chk_offset_off: assert property ((!input_pairing_config_i && selection_mode_i == 2'h2
		&& !offset_alarm_enable_i && loss_alarm_i == '0)[*3] |=> !digital_hold_o) else $error("fos");
	chk_all_lost: assert property ((selection_mode_i inside {2'h1, 2'h2} && loss_alarm_i == '1)[*3]
		|=> digital_hold_o) else $error("all lost");
	chk_hold_dark: assert property (digital_hold_o |-> active_onehot_o == '0) else $error("dark");
	chk_onehot_map: assert property (!digital_hold_o && !$past(input_pairing_config_i)
		|-> active_onehot_o == (INPUTS'(1) << active_choice_o)) else $error("onehot");
	// Main scenarios reached
	cover property (switch_pulse_o);
	cover property (digital_hold_o);
	cover property (lock_lost_o);
endmodule : selector_checker

bind input_clock_selector selector_checker #(.INPUTS(INPUTS)) chk (.clk_i, .rst_i,
	.input_pairing_config_i, .selection_mode_i, .manual_input_choice_i, .pin_choice_enable_i,
	.clock_choice_pins_i, .rank_1_source_i, .offset_alarm_enable_i, .loss_alarm_i,
	.offset_alarm_i, .active_choice_o, .active_onehot_o, .digital_hold_o, .switch_pulse_o,
	.lock_lost_o);

// >>> ref_source_model.sv
`timescale 1ns/10ps
// Reference sources: alarm monitors and board select pins
module ref_source_model (
	input wire logic clk_i,
	output logic [3:0] loss_alarm_o,
	output logic [3:0] offset_alarm_o,
	output logic [1:0] clock_choice_pins_o
);
	// Sources start valid
	initial begin
		loss_alarm_o = 4'h0;
		offset_alarm_o = 4'h0;
		clock_choice_pins_o = 2'h0;
	end
	// Levels move on the falling edge, away from the sampling edge
	task automatic drive(input logic [3:0] l, input logic [3:0] o, input logic [1:0] p);
		@(negedge clk_i);
		loss_alarm_o = l;
		offset_alarm_o = o;
		clock_choice_pins_o = p;
	endtask : drive
endmodule : ref_source_model

// >>> tb_top.sv
`timescale 1ns/10ps
module tb_top;
	logic clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic pair = 1'h0;
	logic pen = 1'h0;
	logic oen = 1'h1;
	logic [1:0] mode = 2'h0;
	logic [1:0] man = 2'h0;
	logic [1:0] valid = 2'h0;
	logic [1:0] r1 = 2'h3;
	logic [1:0] r2 = 2'h2;
	logic [3:0] loss;
	logic [3:0] off;
	logic [1:0] pins;
	logic [1:0] choice;
	logic hold;
	logic hitless;
	logic lock;
	int miscompares = 0;
	int checks_done = 0;
	// Free-running 100 MHz clock
	initial forever #5 clk_i = ~clk_i;
	ref_source_model src (.clk_i(clk_i), .loss_alarm_o(loss), .offset_alarm_o(off),
		.clock_choice_pins_o(pins));
	input_clock_selector #(.LOCK_LOST_LEN(2)) uut (.clk_i(clk_i), .rst_i(rst_i),
		.input_pairing_config_i(pair), .selection_mode_i(mode), .manual_input_choice_i(man),
		.pin_choice_enable_i(pen), .clock_choice_pins_i(pins), .priority_order_i(1'h0),
		.rank_1_source_i(r1), .rank_2_source_i(r2), .rank_3_source_i(2'h1),
		.rank_4_source_i(2'h0), .validation_period_i(valid), .offset_alarm_enable_i(oen),
		.loss_alarm_i(loss), .offset_alarm_i(off), .active_choice_o(choice),
		.active_onehot_o(), .digital_hold_o(hold), .switch_pulse_o(), .hitless_o(hitless),
		.lock_lost_o(lock));
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [3:0] got, input logic [3:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	// One setting, then wait out the two-edge alarm path; choice matters only outside hold
	task automatic step(input logic [1:0] m, p, c, e, input logic [1:0] pn,
		input logic [3:0] l, o, input logic oe, input logic [1:0] ec, input logic eh);
		src.drive(l, o, pn);
		mode = m;
		pair = p[0];
		man = c;
		pen = e[0];
		oen = oe;
		repeat (3) @(negedge clk_i);
		check(hold, eh);
		if (!eh) check(choice, ec);
	endtask : step
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : complete_run
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge clk_i);
		@(negedge clk_i);
		rst_i = 1'h0;
		// Pins show the inverse code, so only the register may win
		for (int i = 0; i < 4; i++) step(0, 0, 2'(i), 0, 2'(~i), 0, 0, 1, 2'(i), 0);
		step(0, 0, 1, 1, 3, 4'h0, 4'h0, 1, 3, 0);
		step(0, 0, 2, 0, 0, 4'h4, 4'h0, 1, 0, 1);
		step(0, 1, 1, 0, 0, 4'h0, 4'h0, 1, 1, 0);
		step(0, 1, 2, 0, 0, 4'h0, 4'h0, 1, 0, 1);
		step(2, 0, 0, 1, 0, 4'h0, 4'h0, 1, 3, 0);
		step(2, 0, 0, 1, 0, 4'h8, 4'h0, 1, 2, 0);
		check(lock, 1'h1);
		step(2, 0, 0, 0, 0, 4'h0, 4'h0, 1, 3, 0);
		step(1, 0, 0, 0, 0, 4'h8, 4'h0, 1, 2, 0);
		step(1, 0, 0, 0, 0, 4'h0, 4'h0, 1, 2, 0);
		step(1, 0, 0, 0, 0, 4'h0, 4'h4, 0, 2, 0);
		valid = 2'h1;
		step(1, 0, 0, 0, 0, 4'h0, 4'h4, 1, 1, 0);
		check(hitless, 1'h1);
		step(1, 0, 0, 0, 0, 4'hf, 4'h0, 0, 0, 1);
		r1 = 2'h1;
		r2 = 2'h0;
		step(2, 1, 0, 0, 0, 4'h0, 4'h0, 1, 1, 0);
		step(2, 1, 0, 0, 0, 4'h8, 4'h0, 1, 0, 0);
		complete_run();
	end
endmodule : tb_top
